/* verilog/sbr_pkg.sv */
// Package: constants and types for the identification and read-length register bank
package sbr_pkg;

	// Register indices
	localparam logic [7:0] IDX_RESERVED4 = 8'h04;
	localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
	localparam logic [7:0] IDX_CLASS_NUM = 8'h06;
	localparam logic [7:0] IDX_READ_LEN = 8'h07;

	// Read values
	localparam logic [7:0] RESERVED4_VALUE = 8'hFF;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
	localparam logic [4:0] READ_LEN_RESET = 5'h08;
	localparam int READ_LEN_MSB = 4;
	localparam logic [2:0] READ_LEN_PAD = 3'h0;

	// Identity fields; values are arbitrary
	localparam logic [3:0] SILICON_REVISION_CODE = 4'h3;
	localparam logic [3:0] MAKER_CODE = 4'hA;
	localparam logic [1:0] DEVICE_CLASS_CODE = 2'h2;
	localparam logic [5:0] DEVICE_NUMBER_CODE = 6'h15;

	// Seven-bit bus addresses picked by the address select pin
	localparam logic [6:0] BUS_ADDR_LOW = 7'h6B;
	localparam logic [6:0] BUS_ADDR_MID = 7'h6C;
	localparam logic [6:0] BUS_ADDR_HIGH = 7'h6D;
	localparam logic [1:0] ADDR_SEL_LOW = 2'h0;
	localparam logic [1:0] ADDR_SEL_MID = 2'h1;
	localparam logic [1:0] ADDR_SEL_HIGH = 2'h2;

	// Serial engine
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_ACK_PEND,
		ST_ACK,
		ST_SEND,
		ST_HOST_ACK,
		ST_NEXT
	} sbr_state_e;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_INDEX,
		PH_COUNT,
		PH_WDATA
	} sbr_phase_e;

	// One sample of the two bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} sbr_line_s;

endpackage

/* verilog/sbr_regs.sv */
// SMBus slave with identification bytes and the block read-length register
// Operation
// - Index five reads revision code high nibble, maker code low nibble, read-only.
// - Index six reads two-bit class code over six-bit device number, read-only.
// - Index seven bits four to zero hold a writable read-length field.
// - Read-length field resets to eight, so a fresh block read returns eight.
// - Index seven bits seven to five are reserved, read zero, no effect.
// - Block read: index write, repeated start, count then consecutive bytes, host NACK ends.
// - Index four is reserved and always reads all ones.
`timescale 1ns/1ps

module sbr_regs (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [1:0] bus_address_select_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic [4:0] read_length_field
);

	////////////////////////////////////////////////////////////////////////////////
	// Line synchronisers and edge detect

	sbr_pkg::sbr_line_s meta_ff, sync_ff, last_ff;
	sbr_pkg::sbr_line_s nxt_meta, nxt_sync, nxt_last;
	logic [1:0] sel_meta_ff, sel_sync_ff, nxt_sel_meta, nxt_sel_sync;

	always_comb begin
		nxt_meta = '{scl: scl_in, sda: sda_in};
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
		nxt_sel_meta = bus_address_select_pin;
		nxt_sel_sync = sel_meta_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_ff <= '{scl: 1'b1, sda: 1'b1};
			sync_ff <= '{scl: 1'b1, sda: 1'b1};
			last_ff <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
		end
	end

	// Strap sync runs through reset so the latch sees the pin at release
	always_ff @(posedge ref_clk) begin
		sel_meta_ff <= nxt_sel_meta;
		sel_sync_ff <= nxt_sel_sync;
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;

	always_comb begin
		scl_rise = sync_ff.scl & ~last_ff.scl;
		scl_fall = ~sync_ff.scl & last_ff.scl;
		bus_start = sync_ff.scl & last_ff.scl & last_ff.sda & ~sync_ff.sda;
		bus_stop = sync_ff.scl & last_ff.scl & ~last_ff.sda & sync_ff.sda;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus address latched once after reset release

	logic [6:0] addr_ff, nxt_addr;
	logic addr_done_ff, nxt_addr_done;

	always_comb begin
		nxt_addr = addr_ff;
		nxt_addr_done = 1'b1;
		if (!addr_done_ff) begin
			unique case (sel_sync_ff)
				sbr_pkg::ADDR_SEL_MID: nxt_addr = sbr_pkg::BUS_ADDR_MID;
				sbr_pkg::ADDR_SEL_HIGH: nxt_addr = sbr_pkg::BUS_ADDR_HIGH;
				default: nxt_addr = sbr_pkg::BUS_ADDR_LOW;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addr_ff <= sbr_pkg::BUS_ADDR_LOW;
			addr_done_ff <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			addr_done_ff <= nxt_addr_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read mux

	logic [4:0] len_ff, nxt_len;
	logic [7:0] idx_ff, nxt_idx;
	logic [7:0] rd_byte;

	always_comb begin
		unique case (idx_ff)
			sbr_pkg::IDX_RESERVED4: rd_byte = sbr_pkg::RESERVED4_VALUE;
			sbr_pkg::IDX_REV_VENDOR: rd_byte = {sbr_pkg::SILICON_REVISION_CODE,
				sbr_pkg::MAKER_CODE};
			sbr_pkg::IDX_CLASS_NUM: rd_byte = {sbr_pkg::DEVICE_CLASS_CODE,
				sbr_pkg::DEVICE_NUMBER_CODE};
			sbr_pkg::IDX_READ_LEN: rd_byte = {sbr_pkg::READ_LEN_PAD, len_ff};
			default: rd_byte = sbr_pkg::UNMAPPED_VALUE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial engine

	sbr_pkg::sbr_state_e state_ff, nxt_state;
	sbr_pkg::sbr_phase_e phase_ff, nxt_phase;
	logic [7:0] shift_ff, nxt_shift;
	logic [2:0] bit_ff, nxt_bit;
	logic [4:0] left_ff, nxt_left;
	logic oe_n_ff, nxt_oe_n;
	logic read_pend_ff, nxt_read_pend;

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_shift = shift_ff;
		nxt_bit = bit_ff;
		nxt_left = left_ff;
		nxt_idx = idx_ff;
		nxt_len = len_ff;
		if (bus_start) begin
			nxt_state = sbr_pkg::ST_RECV;
			nxt_phase = sbr_pkg::PH_ADDR;
			nxt_bit = 3'h0;
		end else if (bus_stop) begin
			nxt_state = sbr_pkg::ST_IDLE;
		end else begin
			unique case (state_ff)
				sbr_pkg::ST_IDLE: nxt_state = sbr_pkg::ST_IDLE;
				sbr_pkg::ST_RECV: begin
					if (scl_rise) begin
						nxt_shift = {shift_ff[6:0], sync_ff.sda};
						nxt_bit = bit_ff + 3'h1;
						if (bit_ff == sbr_pkg::LAST_BIT) begin
							nxt_state = sbr_pkg::ST_ACK_PEND;
						end
					end
				end
				sbr_pkg::ST_ACK_PEND: begin
					if (scl_fall) begin
						nxt_state = sbr_pkg::ST_ACK;
						unique case (phase_ff)
							sbr_pkg::PH_ADDR: begin
								if (shift_ff[7:1] != addr_ff) begin
									nxt_state = sbr_pkg::ST_IDLE;
								end else if (shift_ff[0]) begin
									nxt_phase = sbr_pkg::PH_WDATA;
									nxt_left = len_ff;
								end else begin
									nxt_phase = sbr_pkg::PH_INDEX;
								end
							end
							sbr_pkg::PH_INDEX: begin
								nxt_idx = shift_ff;
								nxt_phase = sbr_pkg::PH_COUNT;
							end
							sbr_pkg::PH_COUNT: nxt_phase = sbr_pkg::PH_WDATA;
							sbr_pkg::PH_WDATA: begin
								if (idx_ff == sbr_pkg::IDX_READ_LEN) begin
									nxt_len = shift_ff[sbr_pkg::READ_LEN_MSB:0];
								end
								nxt_idx = idx_ff + 8'h01;
							end
						endcase
					end
				end
				sbr_pkg::ST_ACK: begin
					if (scl_fall) begin
						nxt_bit = 3'h0;
						nxt_state = sbr_pkg::ST_RECV;
						if (read_pend_ff) begin
							nxt_state = sbr_pkg::ST_SEND;
							nxt_shift = {sbr_pkg::READ_LEN_PAD, left_ff};
						end
					end
				end
				sbr_pkg::ST_SEND: begin
					if (scl_fall) begin
						nxt_shift = {shift_ff[6:0], 1'b1};
						nxt_bit = bit_ff + 3'h1;
						if (bit_ff == sbr_pkg::LAST_BIT) begin
							nxt_state = sbr_pkg::ST_HOST_ACK;
						end
					end
				end
				sbr_pkg::ST_HOST_ACK: begin
					if (scl_rise) begin
						nxt_state = sync_ff.sda ? sbr_pkg::ST_IDLE : sbr_pkg::ST_NEXT;
					end
				end
				sbr_pkg::ST_NEXT: begin
					if (scl_fall) begin
						if (left_ff == 5'h00) begin
							nxt_state = sbr_pkg::ST_IDLE;
						end else begin
							nxt_state = sbr_pkg::ST_SEND;
							nxt_shift = rd_byte;
							nxt_idx = idx_ff + 8'h01;
							nxt_left = left_ff - 5'h01;
							nxt_bit = 3'h0;
						end
					end
				end
			endcase
		end
		unique case (nxt_state)
			sbr_pkg::ST_ACK: nxt_oe_n = 1'b0;
			sbr_pkg::ST_SEND: nxt_oe_n = nxt_shift[7];
			default: nxt_oe_n = 1'b1;
		endcase
	end

	// Read direction remembered from the address byte until its ACK ends

	always_comb begin
		nxt_read_pend = read_pend_ff;
		if (state_ff == sbr_pkg::ST_ACK_PEND && scl_fall && phase_ff == sbr_pkg::PH_ADDR) begin
			nxt_read_pend = shift_ff[0];
		end else if (state_ff != sbr_pkg::ST_ACK && state_ff != sbr_pkg::ST_ACK_PEND) begin
			nxt_read_pend = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_ff <= sbr_pkg::ST_IDLE;
			phase_ff <= sbr_pkg::PH_ADDR;
			shift_ff <= 8'h00;
			bit_ff <= 3'h0;
			left_ff <= 5'h00;
			idx_ff <= 8'h00;
			len_ff <= sbr_pkg::READ_LEN_RESET;
			oe_n_ff <= 1'b1;
			read_pend_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			shift_ff <= nxt_shift;
			bit_ff <= nxt_bit;
			left_ff <= nxt_left;
			idx_ff <= nxt_idx;
			len_ff <= nxt_len;
			oe_n_ff <= nxt_oe_n;
			read_pend_ff <= nxt_read_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		sda_out = 1'b0;
		sda_oe_n = oe_n_ff;
		read_length_field = len_ff;
	end

endmodule

/* test/sbr_regs_checker.sv */
// Checker: port-level properties of the register bank
`timescale 1ns/1ps
module sbr_regs_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [1:0] bus_address_select_pin,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic [4:0] read_length_field
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_pull_only: assert property (sda_out == 1'b0) else $error("sda driven high");
	a_reset_len: assert property ($fell(sys_rst) |-> read_length_field == 5'h08 && sda_oe_n)
		else $error("bad state after reset");
	a_len_scl_low: assert property ($changed(read_length_field) |-> !scl_in)
		else $error("length changed with scl high");
	a_len_after_ack: assert property ($changed(read_length_field) |-> $fell(sda_oe_n))
		else $error("length changed away from an ack");
	a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("sda drive changed with scl high");
	a_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4])
		else $error("drive too short");
	a_drive_late: assert property ($fell(sda_oe_n) |-> $past(scl_in, 8))
		else $error("drive not after scl fall");
	a_start_idle: assert property ($fell(sda_in) && scl_in |-> sda_oe_n)
		else $error("device drove during start");
	c_ack: cover property ($fell(sda_oe_n));
	c_len: cover property ($changed(read_length_field));
	c_start: cover property ($fell(sda_in) && scl_in);
endmodule
bind sbr_regs sbr_regs_checker sbr_regs_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.bus_address_select_pin(bus_address_select_pin), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .read_length_field(read_length_field));

/* test/sbr_host.sv */
// Host controller model: drives the clock line and pulls the data line
`timescale 1ns/1ps
module sbr_host (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_h
);
	logic s;
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic hp;
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic clk_bit(input logic b, output logic v);
		sda_h <= b;
		hp();
		scl <= 1'b1;
		hp();
		v = sda;
		scl <= 1'b0;
	endtask
	task automatic start;
		sda_h <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sda_h <= 1'b0;
		hp();
		scl <= 1'b0;
	endtask
	task automatic stop;
		sda_h <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sda_h <= 1'b1;
		hp();
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic nak);
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, nak);
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
		clk_bit(last, s);
	endtask
endmodule

/* test/tb_sbr_regs.sv */
// Testbench: block reads and writes through the serial pins
`timescale 1ns/1ps
module tb_sbr_regs;
	logic ref_clk;
	logic sys_rst;
	logic [1:0] bus_address_select_pin;
	logic scl;
	logic sda_h;
	logic sda_out;
	logic sda_oe_n;
	logic [4:0] read_length_field;
	logic [4:0] len_exp;
	logic [7:0] addr;
	logic nak;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	wire sda = sda_h & (sda_oe_n | sda_out);
	sbr_regs sbr_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.bus_address_select_pin(bus_address_select_pin), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .read_length_field(read_length_field));
	sbr_host sbr_host_i (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_h(sda_h));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] map(input logic [7:0] idx);
		case (idx)
			8'h04: return 8'hFF;
			8'h05: return {sbr_pkg::SILICON_REVISION_CODE, sbr_pkg::MAKER_CODE};
			8'h06: return {sbr_pkg::DEVICE_CLASS_CODE, sbr_pkg::DEVICE_NUMBER_CODE};
			8'h07: return {3'h0, len_exp};
			default: return 8'h00;
		endcase
	endfunction
	task automatic wr_bytes(input logic [7:0] idx, input logic [23:0] d, input int n);
		sbr_host_i.start();
		sbr_host_i.wr_byte(addr, nak);
		check({7'h0, nak}, 8'h00);
		sbr_host_i.wr_byte(idx, nak);
		sbr_host_i.wr_byte(n[7:0], nak);
		for (int i = 0; i < n; i++) begin
			sbr_host_i.wr_byte(d[23 - 8 * i -: 8], nak);
			check({7'h0, nak}, 8'h00);
		end
		sbr_host_i.stop();
	endtask
	task automatic rd_block(input logic [7:0] idx);
		logic [7:0] b;
		sbr_host_i.start();
		sbr_host_i.wr_byte(addr, nak);
		sbr_host_i.wr_byte(idx, nak);
		sbr_host_i.start();
		sbr_host_i.wr_byte(addr | 8'h01, nak);
		check({7'h0, nak}, 8'h00);
		sbr_host_i.rd_byte(len_exp == 5'h00, b);
		check(b, {3'h0, len_exp});
		for (int i = 0; i < len_exp; i++) begin
			sbr_host_i.rd_byte(i == len_exp - 1, b);
			check(b, map(idx + i[7:0]));
		end
		sbr_host_i.stop();
	endtask
	task automatic do_reset(input logic [1:0] sel);
		sys_rst <= 1'b1;
		bus_address_select_pin <= sel;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		len_exp = 5'h08;
	endtask
	initial begin
		sys_rst = 1'b1;
		bus_address_select_pin = 2'h0;
		addr = {sbr_pkg::BUS_ADDR_LOW, 1'b0};
		do_reset(2'h0);
		check({3'h0, read_length_field}, 8'h08);
		rd_block(8'h04);
		wr_bytes(8'h07, 24'hFF0000, 1);
		len_exp = 5'h1F;
		check({3'h0, read_length_field}, 8'h1F);
		rd_block(8'h06);
		wr_bytes(8'h05, 24'h0000E4, 3);
		len_exp = 5'h04;
		rd_block(8'h04);
		do_reset(2'h1);
		sbr_host_i.start();
		sbr_host_i.wr_byte({sbr_pkg::BUS_ADDR_LOW, 1'b0}, nak);
		sbr_host_i.stop();
		check({7'h0, nak}, 8'h01);
		addr = {sbr_pkg::BUS_ADDR_MID, 1'b0};
		rd_block(8'h05);
		do_reset(2'h2);
		addr = {sbr_pkg::BUS_ADDR_HIGH, 1'b0};
		sbr_host_i.start();
		sbr_host_i.wr_byte(addr, nak);
		sbr_host_i.stop();
		check({7'h0, nak}, 8'h00);
		do_reset(2'h3);
		addr = {sbr_pkg::BUS_ADDR_LOW, 1'b0};
		rd_block(8'h07);
		finish_test();
	end
endmodule
